// ===== modem_pkg.sv
// Shared constants, types and helpers for the modem host port ends
// Functional notes
// - Host read strobe returns addressed port data
// - Host write strobe stores data into port
// - Decode only while address enable low
// - Compare system address with configured base
// - One of eight interrupt lines, config-selected
// - Selected interrupt line high on request
// - Reset high initialises all logic; io_base loads 07FH, controller-end synchronisers all ones, host-end synchronisers all zeros
// - Bank pins: 00,10,01,11 for banks 0-3
// - 256K banked program, 64K data space
// - RX DSP select low at E400H region
// - Loop current input is bit0 at D000H
// - External mode: data pins output port E800H
// - External mode: low address pins input E800H
// - Internal mode: data pins carry both ways
// - Program write enable low only for flash
// - Serial: 6-8 bits, parity kinds, 1-2 stops
// - Terminal side up to 115200 bps
// - Base and interrupt set by autoconfig/software
// - Mode select low internal, high external
// - Autoconfig enable low arms initiation key
package modem_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ    = 50;
  localparam int STROBE_NS  = 400;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_DEPTH = 3;

  // ==========================================================
  // Host side port map
  localparam int          UART_PORTS    = 8;
  localparam logic [12:0] IO_BASE_RST   = 13'h07F;
  localparam logic [2:0]  IRQ_SEL_RST   = 3'h0;
  localparam logic [15:0] PNP_ADDR_PORT = 16'h0279;
  localparam logic [7:0]  PNP_KEY_SEED  = 8'h6A;
  localparam logic [4:0]  PNP_KEY_LAST  = 5'h1F;

  // ==========================================================
  // Controller memory map
  localparam logic [15:0] MCU_DAA     = 16'hD000;
  localparam logic [15:0] MCU_CFG     = 16'hDC00;
  localparam logic [15:0] MCU_UART    = 16'hE000;
  localparam logic [15:0] MCU_RXDSP   = 16'hE400;
  localparam logic [15:0] MCU_MDM     = 16'hE800;
  localparam logic [15:0] MASK_RXDSP  = 16'hFC00;
  localparam logic [15:0] MASK_PORT8  = 16'hFFF8;
  localparam logic [15:0] MASK_ONE    = 16'hFFFF;
  localparam logic [2:0]  CFG_BASE_LO = 3'h0;
  localparam logic [2:0]  CFG_BASE_HI = 3'h1;
  localparam logic [2:0]  CFG_IRQ     = 3'h2;
  localparam logic [2:0]  CFG_STAT    = 3'h3;
  localparam logic [2:0]  CFG_BANK    = 3'h4;
  localparam logic [2:0]  CFG_WFLAG   = 3'h5;

  // ==========================================================
  // Host command registers (AXI4-Lite byte offsets)
  localparam logic [3:0] REG_CMD   = 4'h0;
  localparam logic [3:0] REG_ADDR  = 4'h4;
  localparam logic [3:0] REG_STAT  = 4'h8;
  localparam logic [3:0] REG_RDATA = 4'hC;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  typedef enum logic [1:0] {
    CYC_IDLE   = 2'b00,
    CYC_SETUP  = 2'b01,
    CYC_STROBE = 2'b10,
    CYC_HOLD   = 2'b11
  } cyc_state_t;

  // Address falls in region base/mask
  function automatic logic in_region(input logic [15:0] a, input logic [15:0] base,
                                     input logic [15:0] mask);
    return (a & mask) == base;
  endfunction

  // Settled level: follows only when stages two and three agree
  function automatic logic [31:0] settle(input logic [31:0] s2, input logic [31:0] s3,
                                         input logic [31:0] held);
    return (s2 & s3) | (held & (s2 | s3));
  endfunction

endpackage

// ===== isa_port_if.sv
// ISA I/O port wires joining the host end and the modem controller end
`timescale 1ns/1ps
interface isa_port_if;
  logic       aen_n;
  logic       ior_n;
  logic       iow_n;
  logic [15:0] addr;
  logic [7:0] host_dout;
  logic       host_oe_n;
  logic [7:0] dev_dout;
  logic       dev_oe_n;
  logic [7:0] data;
  logic [7:0] irq;

  // Resolved data bus; idle bus floats high
  assign data = !dev_oe_n ? dev_dout : (!host_oe_n ? host_dout : 8'hFF);

  modport dev (
    input  aen_n, ior_n, iow_n, addr, data,
    output dev_dout, dev_oe_n, irq
  );
  modport host (
    input  data, irq,
    output aen_n, ior_n, iow_n, addr, host_dout, host_oe_n
  );
endinterface

// ===== modem_ctrl_host_port.sv
// Modem controller end: ISA virtual UART port, autoconfig, board glue
`timescale 1ns/1ps
module modem_ctrl_host_port
  import modem_pkg::*;
#(
  parameter int NUM_IRQ = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // ISA pins
  isa_port_if.dev           isa,
  // Straps
  input  wire logic         ext_int_mode_select,
  input  wire logic         autoconfig_enable_n,
  input  wire logic         loop_current_detect_n,
  // Controller bus
  input  wire logic [15:0]  mcu_addr,
  input  wire logic         mcu_rd,
  input  wire logic         mcu_wr,
  input  wire logic [7:0]   mcu_wdata,
  output logic [7:0]        mcu_rdata,
  input  wire logic         mcu_prog_wr,
  // Board outputs
  output logic [1:0]        bank_select_outputs,
  output logic              rx_dsp_select_n,
  output logic              program_write_enable_n,
  output logic              autoconfig_mode
);
  import modem_pkg::*;

  // ==========================================================
  // Pin synchronisers: aen, ior, iow, addr, data, straps, loop
  localparam int SW = 30;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] s1, s2, s3, held;
  wire  [31:0]   settled = settle(32'(s2), 32'(s3), 32'(held));
  assign pin_raw = {isa.aen_n, isa.ior_n, isa.iow_n, isa.addr, isa.data,
                    ext_int_mode_select, loop_current_detect_n, autoconfig_enable_n};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      held <= '1;
    end else begin
      s1 <= pin_raw;
      s2 <= s1;
      s3 <= s2;
      held <= settled[SW-1:0];
    end
  end

  wire        aen_n_q  = held[29];
  wire        ior_n_q  = held[28];
  wire        iow_n_q  = held[27];
  wire [15:0] addr_q   = held[26:11];
  wire [7:0]  data_q   = held[10:3];
  wire        ext_q    = held[2];
  wire        loop_q   = held[1];
  wire        acfg_n_q = held[0];

  // ==========================================================
  // Configuration state
  logic [12:0] io_base;
  logic [2:0]  irq_sel;
  logic        irq_en;
  logic        irq_req;
  logic [1:0]  bank;
  logic        flash_en;
  logic [7:0]  mdm_out;
  logic [7:0]  host_wflag;
  logic [7:0]  uart_reg [UART_PORTS];
  logic [7:0]  key_lfsr;
  logic [4:0]  key_cnt;
  logic        iow_n_d;

  // ==========================================================
  // Host cycle decode
  wire host_hit   = !aen_n_q && (addr_q[15:3] == io_base);
  wire host_wr_end = iow_n_q && !iow_n_d && !aen_n_q;
  wire port_wr    = host_wr_end && host_hit && !ext_q;
  wire key_wr     = host_wr_end && (addr_q == PNP_ADDR_PORT) && !acfg_n_q;
  wire host_rd    = !ior_n_q && host_hit && !ext_q;
  wire [2:0] port_ix = addr_q[2:0];
  wire [7:0] next_lfsr = {key_lfsr[0] ^ key_lfsr[1], key_lfsr[7:1]};

  // Internal mode: drive only during decoded read; external: output port
  assign isa.dev_oe_n = !(host_rd || ext_q);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      isa.dev_dout <= 8'h00;
    end else begin
      isa.dev_dout <= ext_q ? mdm_out : uart_reg[port_ix];
    end
  end

  // One-hot line from the select field, gated by enable and request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      isa.irq <= 8'h00;
    end else begin
      isa.irq <= (irq_en && irq_req) ? NUM_IRQ'(1) << irq_sel : 8'h00;
    end
  end

  // ==========================================================
  // Controller decode
  wire mcu_cfg   = in_region(mcu_addr, MCU_CFG, MASK_PORT8);
  wire mcu_uart  = in_region(mcu_addr, MCU_UART, MASK_PORT8);
  wire mcu_daa   = in_region(mcu_addr, MCU_DAA, MASK_ONE);
  wire mcu_mdm   = in_region(mcu_addr, MCU_MDM, MASK_ONE);
  wire mcu_rxdsp = in_region(mcu_addr, MCU_RXDSP, MASK_RXDSP);
  wire [2:0] mix = mcu_addr[2:0];
  wire cfg_wr    = mcu_wr && mcu_cfg;

  assign rx_dsp_select_n = !((mcu_rd || mcu_wr) && mcu_rxdsp);
  // Flash writes pass only once software has armed them
  assign program_write_enable_n = !(flash_en && mcu_prog_wr);

  logic [7:0] cfg_rd;
  always_comb begin
    case (mix)
      CFG_BASE_LO: cfg_rd = io_base[7:0];
      CFG_BASE_HI: cfg_rd = {3'h0, io_base[12:8]};
      CFG_IRQ:     cfg_rd = {2'h0, irq_req, irq_en, 1'b0, irq_sel};
      CFG_STAT:    cfg_rd = {6'h0, ext_q, autoconfig_mode};
      CFG_BANK:    cfg_rd = {5'h0, flash_en, bank};
      CFG_WFLAG:   cfg_rd = host_wflag;
      default:     cfg_rd = 8'h00;
    endcase
  end

  wire [7:0] next_rdata = mcu_daa  ? {7'h00, loop_q} :
                          mcu_mdm  ? addr_q[7:0] :
                          mcu_uart ? uart_reg[mix] :
                          mcu_cfg  ? cfg_rd : 8'h00;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mcu_rdata <= 8'h00;
    end else if (mcu_rd) begin
      mcu_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Virtual UART ports: host writes, controller writes
  // Serial format and rate live in firmware behind these ports
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < UART_PORTS; i++) begin
        uart_reg[i] <= 8'h00;
      end
    end else if (port_wr) begin
      uart_reg[port_ix] <= data_q;
    end else if (mcu_wr && mcu_uart) begin
      uart_reg[mix] <= mcu_wdata;
    end
  end

  // Host-write flags: a new host write beats a same-cycle clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_wflag <= 8'h00;
    end else begin
      host_wflag <= (host_wflag & ~((cfg_wr && mix == CFG_WFLAG) ? mcu_wdata : 8'h00))
                    | (port_wr ? 8'(1) << port_ix : 8'h00);
    end
  end

  // ==========================================================
  // Configuration, banking and modem control port
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_base  <= IO_BASE_RST;
      irq_sel  <= IRQ_SEL_RST;
      irq_en   <= 1'b0;
      irq_req  <= 1'b0;
      bank     <= 2'h0;
      flash_en <= 1'b0;
      mdm_out  <= 8'h00;
    end else begin
      if (cfg_wr && mix == CFG_BASE_LO) begin
        io_base[7:0] <= mcu_wdata;
      end
      if (cfg_wr && mix == CFG_BASE_HI) begin
        io_base[12:8] <= mcu_wdata[4:0];
      end
      if (cfg_wr && mix == CFG_IRQ) begin
        irq_sel <= mcu_wdata[2:0];
        irq_en  <= mcu_wdata[4];
        irq_req <= mcu_wdata[5];
      end
      if (cfg_wr && mix == CFG_BANK) begin
        bank     <= mcu_wdata[1:0];
        flash_en <= mcu_wdata[2];
      end
      if (mcu_wr && mcu_mdm) begin
        mdm_out <= mcu_wdata;
      end
    end
  end

  // Bank field bit0 drives the first pin, bit1 the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_select_outputs <= 2'b00;
    end else begin
      bank_select_outputs <= bank;
    end
  end

  // ==========================================================
  // Initiation key: a wrong byte restarts the sequence
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      iow_n_d         <= 1'b1;
      key_lfsr        <= PNP_KEY_SEED;
      key_cnt         <= 5'h00;
      autoconfig_mode <= 1'b0;
    end else begin
      iow_n_d <= iow_n_q;
      if (acfg_n_q) begin
        autoconfig_mode <= 1'b0;
        key_cnt         <= 5'h00;
        key_lfsr        <= PNP_KEY_SEED;
      end else if (key_wr) begin
        if (data_q == key_lfsr) begin
          key_lfsr <= next_lfsr;
          key_cnt  <= key_cnt + 5'h01;
          if (key_cnt == PNP_KEY_LAST) begin
            autoconfig_mode <= 1'b1;
          end
        end else begin
          key_lfsr <= PNP_KEY_SEED;
          key_cnt  <= 5'h00;
        end
      end
    end
  end

endmodule

// ===== isa_host_master.sv
// Host end: AXI4-Lite command registers driving ISA I/O cycles
`timescale 1ns/1ps
module isa_host_master
  import modem_pkg::*;
#(
  parameter int STROBE_CYCLES = STROBE_CYC
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // ISA pins
  isa_port_if.host          isa,
  // AXI4-Lite write
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready
);
  import modem_pkg::*;

  // ==========================================================
  // Pin synchronisers for data and interrupt lines
  logic [15:0] s1, s2, s3, held;
  wire  [31:0] settled = settle(32'(s2), 32'(s3), 32'(held));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      held <= '0;
    end else begin
      s1 <= {isa.irq, isa.data};
      s2 <= s1;
      s3 <= s2;
      held <= settled[15:0];
    end
  end

  // ==========================================================
  // AXI write channel: address and data latched in either order
  logic [3:0]  aw_q;
  logic [31:0] w_q;
  logic        aw_have, w_have;
  logic [15:0] cyc_addr;
  logic [7:0]  cyc_wdata;
  logic [7:0]  rd_byte;
  logic        cyc_read;
  logic        busy;
  cyc_state_t  state;
  logic [15:0] cnt;

  assign s_axi_awready = !aw_have && !s_axi_bvalid;
  assign s_axi_wready  = !w_have && !s_axi_bvalid;
  wire do_wr  = aw_have && w_have && !s_axi_bvalid;
  wire go     = do_wr && aw_q == REG_CMD && !busy && s_axi_wstrb[1];
  wire wr_ok  = aw_q == REG_CMD || aw_q == REG_ADDR;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have      <= 1'b0;
      w_have       <= 1'b0;
      aw_q         <= 4'h0;
      w_q          <= 32'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
      cyc_addr     <= 16'h0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have <= 1'b1;
        w_q    <= s_axi_wdata;
      end
      if (do_wr) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
        if (aw_q == REG_ADDR && !busy) begin
          cyc_addr <= w_q[15:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      REG_ADDR:  rd_mux = {16'h0000, cyc_addr};
      REG_STAT:  rd_mux = {23'h0, held[15:8], busy};
      REG_RDATA: rd_mux = {24'h0, rd_byte};
      default:   rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= (s_axi_araddr == REG_CMD) ? RESP_ERR : RESP_OK;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // ISA cycle: setup, strobe for a fixed width, one hold cycle
  assign busy = state != CYC_IDLE;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= CYC_IDLE;
      cnt           <= 16'h0000;
      cyc_read      <= 1'b0;
      cyc_wdata     <= 8'h00;
      rd_byte       <= 8'h00;
      isa.aen_n     <= 1'b1;
      isa.ior_n     <= 1'b1;
      isa.iow_n     <= 1'b1;
      isa.addr      <= 16'h0000;
      isa.host_dout <= 8'h00;
      isa.host_oe_n <= 1'b1;
    end else begin
      case (state)
        CYC_IDLE: begin
          if (go) begin
            cyc_read  <= w_q[8];
            cyc_wdata <= w_q[7:0];
            isa.addr  <= cyc_addr;
            isa.aen_n <= 1'b0;
            state     <= CYC_SETUP;
          end
        end
        CYC_SETUP: begin
          isa.ior_n     <= !cyc_read;
          isa.iow_n     <= cyc_read;
          isa.host_dout <= cyc_wdata;
          isa.host_oe_n <= cyc_read;
          cnt           <= 16'(STROBE_CYCLES);
          state         <= CYC_STROBE;
        end
        CYC_STROBE: begin
          cnt <= cnt - 16'h0001;
          if (cnt == 16'h0001) begin
            if (cyc_read) begin
              rd_byte <= held[7:0];
            end
            isa.ior_n <= 1'b1;
            isa.iow_n <= 1'b1;
            state     <= CYC_HOLD;
          end
        end
        CYC_HOLD: begin
          // Data and address held one cycle past the strobe edge
          isa.host_oe_n <= 1'b1;
          isa.aen_n     <= 1'b1;
          state         <= CYC_IDLE;
        end
        default: state <= CYC_IDLE;
      endcase
    end
  end

endmodule

// ===== modem_port_props.sv
// Concurrent checks on the ISA wires between the host end and the controller end
`timescale 1ns/1ps
module modem_port_props (
  // Clock, reset and mode strap
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ext_int_mode_select,
  // ISA wires
  input wire logic       aen_n,
  input wire logic       ior_n,
  input wire logic       iow_n,
  input wire logic       host_oe_n,
  input wire logic       dev_oe_n,
  input wire logic [7:0] data,
  input wire logic [7:0] irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // Helpers
  // Synchronisers start in external mode, so the drive and write-data checks wait for a settled strap
  logic [3:0] int_cnt;
  logic [3:0] since_rd;
  logic       int_ok;
  assign int_ok = int_cnt == 4'hF;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) int_cnt <= 4'h0;
    else if (ext_int_mode_select) int_cnt <= 4'h0;
    else if (!int_ok) int_cnt <= int_cnt + 4'h1;
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) since_rd <= 4'hF;
    else if (!ior_n) since_rd <= 4'h0;
    else if (since_rd != 4'hF) since_rd <= since_rd + 4'h1;
  end

  // ==========================================================
  // Assertions
  a_irq_one_line: assert property ($onehot0(irq))
    else $error("more than one interrupt line high");
  a_rst_clears_irq: assert property (disable iff (1'b0) sys_rst |-> irq == 8'h00)
    else $error("interrupt line high during reset");
  a_no_bus_fight: assert property (!(!dev_oe_n && !host_oe_n))
    else $error("both ends drive the data bus");
  a_drive_in_read: assert property (int_ok && !dev_oe_n |-> since_rd < 4'h8)
    else $error("device drives bus outside a read");
  a_strobe_in_aen: assert property (!ior_n || !iow_n |-> !aen_n)
    else $error("strobe without address enable");
  a_aen_leads_strobe: assert property ($fell(ior_n) || $fell(iow_n) |-> !$past(aen_n))
    else $error("address enable not set before strobe");
  a_write_drives: assert property (!iow_n |-> !host_oe_n)
    else $error("write strobe without host data");
  a_wdata_stable: assert property (int_ok && !iow_n && !$fell(iow_n) |-> $stable(data))
    else $error("write data moved during strobe");

  c_read: cover property ($rose(ior_n));
  c_write: cover property ($rose(iow_n));
  c_irq: cover property (irq != 8'h00);
endmodule

// ===== testbench.sv
// Self-checking bench joining the host end and the modem controller end
`timescale 1ns/1ps
module testbench;
  import modem_pkg::*;
  logic        clk, sys_rst, ext, acfg_n, loop_n, prog_wr, prog_n, dsp_n, acfg_mode;
  logic        mcu_rd, mcu_wr, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [15:0] mcu_addr, a;
  logic [7:0]  mcu_wdata, mcu_rdata, v, q;
  logic [1:0]  bank;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, s;
  logic [1:0]  bresp, rresp;
  integer      seed, mismatches, comparisons, cycles, i;

  isa_port_if port ();
  modem_ctrl_host_port modem_ctrl_host_port_i (.clk(clk), .sys_rst(sys_rst), .isa(port),
    .ext_int_mode_select(ext), .autoconfig_enable_n(acfg_n), .loop_current_detect_n(loop_n),
    .mcu_addr(mcu_addr), .mcu_rd(mcu_rd), .mcu_wr(mcu_wr), .mcu_wdata(mcu_wdata),
    .mcu_rdata(mcu_rdata), .mcu_prog_wr(prog_wr), .bank_select_outputs(bank),
    .rx_dsp_select_n(dsp_n), .program_write_enable_n(prog_n), .autoconfig_mode(acfg_mode));
  isa_host_master #(.STROBE_CYCLES(12)) isa_host_master_i (.clk(clk), .sys_rst(sys_rst),
    .isa(port), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  modem_port_props modem_port_props_i (.clk(clk), .sys_rst(sys_rst), .ext_int_mode_select(ext),
    .aen_n(port.aen_n), .ior_n(port.ior_n), .iow_n(port.iow_n), .host_oe_n(port.host_oe_n),
    .dev_oe_n(port.dev_oe_n), .data(port.data), .irq(port.irq));

  // ==========================================================
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end

  // ==========================================================
  // Tasks
  task wrap_up;
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strap levels pass synchronisers before they count
  task settle;
    repeat (SYNC_DEPTH + 3) @(posedge clk);
  endtask
  task axi_wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task axi_rd(input logic [3:0] ad, output logic [31:0] d);
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask
  task host_io(input logic rd, input logic [15:0] ad, input logic [7:0] d, output logic [7:0] r);
    axi_wr(REG_ADDR, {16'h0000, ad});
    axi_wr(REG_CMD, {23'h0, rd, d});
    do axi_rd(REG_STAT, s); while (s[0] !== 1'b0);
    axi_rd(REG_RDATA, s);
    r = s[7:0];
    settle;
  endtask
  task mcu(input logic w, input logic [15:0] ad, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    mcu_addr <= ad;
    mcu_rd <= !w;
    mcu_wr <= w;
    mcu_wdata <= d;
    @(posedge clk);
    mcu_rd <= 1'b0;
    mcu_wr <= 1'b0;
    @(posedge clk);
    r = mcu_rdata;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {mcu_rd, mcu_wr, awvalid, wvalid, bready, arvalid, rready, ext, prog_wr} = '0;
    {mcu_addr, mcu_wdata, awaddr, araddr, wdata} = '0;
    {acfg_n, loop_n, sys_rst} = 3'b111;
    seed = 21552;
    {mismatches, comparisons, cycles} = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    settle;
    chk(acfg_mode, 1'b0);
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      host_io(1'b0, 16'h03F8 + i, v, q);
      mcu(1'b0, MCU_UART + i, 8'h00, q);
      chk(q, v);
      v = $random(seed);
      mcu(1'b1, MCU_UART + i, v, q);
      host_io(1'b1, 16'h03F8 + i, 8'h00, q);
      chk(q, v);
    end
    // Move the port block to 0x2F8; the old base must miss
    mcu(1'b1, MCU_UART, 8'h11, q);
    mcu(1'b1, MCU_CFG + CFG_BASE_LO, 8'h5F, q);
    mcu(1'b1, MCU_CFG + CFG_BASE_HI, 8'h00, q);
    host_io(1'b0, 16'h03F8, 8'hEE, q);
    host_io(1'b0, 16'h02F9, 8'h5A, q);
    mcu(1'b0, MCU_UART, 8'h00, q);
    chk(q, 8'h11);
    mcu(1'b0, MCU_UART + 1, 8'h00, q);
    chk(q, 8'h5A);
    axi_wr(REG_STAT, 32'h0);
    chk(bresp, RESP_ERR);
    axi_rd(REG_CMD, s);
    chk(rresp, RESP_ERR);
    for (i = 0; i < 8; i++) begin
      mcu(1'b1, MCU_CFG + CFG_IRQ, 8'h30 | i, q);
      repeat (3) @(posedge clk);
      chk(port.irq, 8'h01 << i);
      axi_rd(REG_STAT, s);
      chk(s[8:1], 8'h01 << i);
      mcu(1'b1, MCU_CFG + CFG_IRQ, 8'h10 | i, q);
      repeat (3) @(posedge clk);
      chk(port.irq, 8'h00);
      axi_rd(REG_STAT, s);
      chk(s[8:1], 8'h00);
      mcu(1'b0, MCU_CFG + CFG_IRQ, 8'h00, q);
      chk(q, 8'h10 | i);
    end
    for (i = 0; i < 4; i++) begin
      mcu(1'b1, MCU_CFG + CFG_BANK, i, q);
      @(posedge clk);
      prog_wr <= 1'b1;
      #1 chk(bank, i);
      chk(prog_n, 1'b1);
      @(posedge clk);
      prog_wr <= 1'b0;
    end
    mcu(1'b1, MCU_CFG + CFG_BANK, 8'h04, q);
    prog_wr <= 1'b1;
    #1 chk(prog_n, 1'b0);
    @(posedge clk);
    prog_wr <= 1'b0;
    for (i = 0; i < 6; i++) begin
      a = $random(seed);
      if (i < 3) a[15:10] = 6'b111001;
      @(posedge clk);
      mcu_addr <= a;
      mcu_rd <= 1'b1;
      #1 chk(dsp_n, (a & 16'hFC00) != 16'hE400);
      @(posedge clk);
      mcu_rd <= 1'b0;
      #1 chk(dsp_n, 1'b1);
    end
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      loop_n <= i;
      settle;
      mcu(1'b0, MCU_DAA, 8'h00, q);
      chk(q[0], i);
    end
    ext <= 1'b1;
    settle;
    mcu(1'b0, MCU_CFG + CFG_STAT, 8'h00, q);
    chk(q[1], 1'b1);
    v = $random(seed);
    mcu(1'b1, MCU_MDM, v, q);
    repeat (2) @(posedge clk);
    chk(port.data, v);
    a = $random(seed);
    axi_wr(REG_ADDR, {16'h0000, a});
    axi_wr(REG_CMD, 32'h100);
    repeat (8) @(posedge clk);
    mcu(1'b0, MCU_MDM, 8'h00, q);
    chk(q, a[7:0]);
    do axi_rd(REG_STAT, s); while (s[0] !== 1'b0);
    axi_rd(REG_RDATA, s);
    chk(s[7:0], v);
    ext <= 1'b0;
    acfg_n <= 1'b0;
    settle;
    v = PNP_KEY_SEED;
    for (i = 0; i < 32; i++) begin
      host_io(1'b0, PNP_ADDR_PORT, v, q);
      v = {v[0] ^ v[1], v[7:1]};
    end
    chk(acfg_mode, 1'b1);
    acfg_n <= 1'b1;
    settle;
    chk(acfg_mode, 1'b0);
    mcu(1'b1, MCU_CFG + CFG_BANK, 8'h03, q);
    mcu(1'b1, MCU_CFG + CFG_IRQ, 8'h30, q);
    sys_rst <= 1'b1;
    @(posedge clk);
    #1 chk({port.irq, bank}, 10'h000);
    @(posedge clk);
    sys_rst <= 1'b0;
    settle;
    mcu(1'b0, MCU_CFG + CFG_BASE_LO, 8'h00, q);
    chk(q, IO_BASE_RST[7:0]);
    wrap_up;
  end
endmodule
